// [tad_pkg.sv]
/*
  Constants, register map and helpers for the transmit alarm and signal-detect block.
  Assumes an 8-bit register port with byte-wide registers at their native offsets.
*/
package tad_pkg;

  // ***********************************************************
  // Register offsets.
  // ***********************************************************
  localparam logic [7:0] ADDR_ALARM = 8'h89;
  localparam logic [7:0] ADDR_SD_CTRL = 8'h8A;
  localparam logic [7:0] ADDR_SD_STAT = 8'h8B;
  localparam logic [7:0] ADDR_ASSERT_THR = 8'h91;
  localparam logic [7:0] ADDR_CLEAR_THR = 8'h92;
  localparam logic [7:0] ADDR_EYE_ASSERT = 8'h9A;
  localparam logic [7:0] ADDR_EYE_DEASSERT = 8'h9B;
  localparam logic [7:0] ADDR_PATH_CFG = 8'h9C;
  localparam logic [7:0] ADDR_PAT_LIMIT = 8'hAF;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hE0;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hE1;

  // ***********************************************************
  // Field positions.
  // ***********************************************************
  localparam int BIT_REF = 6;
  localparam int BIT_SIG = 5;
  localparam int BIT_LOCK = 4;
  localparam int BIT_FIFO = 3;
  localparam int BIT_PERR = 2;
  localparam int BIT_SYNC = 1;
  localparam int BIT_EYE = 0;
  localparam int CTL_EYE_EN = 3;
  localparam int CTL_MODE_LO = 1;
  localparam int ST_EYE = 4;
  localparam int ST_LAST = 3;
  localparam int ST_RUN = 2;
  localparam int ST_SIG = 0;
  localparam int PATH_AUTO = 1;
  localparam int PATH_FIFO_RST = 0;

  // ***********************************************************
  // Reset values and writable masks.
  // ***********************************************************
  localparam logic [7:0] CTRL_RST = 8'h0E;
  localparam logic [7:0] CTRL_WMASK = 8'h0E;
  localparam logic [7:0] ALARM_MASK = 8'h7F;
  localparam logic [7:0] EYE_A_RST = 8'h05;
  localparam logic [7:0] EYE_D_RST = 8'h08;
  localparam logic [7:0] EYE_D_WMASK = 8'h3F;
  localparam logic [7:0] PATH_WMASK = 8'h02;
  localparam logic [7:0] PAT_LIMIT_RST = 8'hFF;

  // ***********************************************************
  // Run-length detector arithmetic.
  // ***********************************************************
  localparam int RL_BLOCK_BITS = 1024;
  localparam int RL_ASSERT_MUL = 5;
  localparam int RL_ASSERT_ADD = 2;
  localparam int RL_CLEAR_MUL = 16;
  localparam int RL_CLEAR_ADD = 1;
  localparam logic [1:0] RL_OFF = 2'h0;
  localparam logic [1:0] RL_ZEROS = 2'h1;

  typedef logic [20:0] tad_run_t;
  typedef logic [12:0] tad_clr_t;

  function automatic tad_run_t tad_assert_len(input logic [7:0] thr, input int blk);
    return tad_run_t'((int'(thr) * RL_ASSERT_MUL + RL_ASSERT_ADD) * blk);
  endfunction

  function automatic tad_clr_t tad_clear_len(input logic [7:0] thr);
    return tad_clr_t'(int'(thr) * RL_CLEAR_MUL + RL_CLEAR_ADD);
  endfunction

endpackage

// [tad_run_detect.sv]
/*
  Run-length signal-absence detector on the transmit serial bit stream.
  Assumes one bit per enabled cycle on bit_i, qualified by valid_i.
*/
`timescale 1ns/1ns
module tad_run_detect
  import tad_pkg::*;
#(
  parameter int BLOCK_BITS = RL_BLOCK_BITS
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Bit stream.
  input wire logic bit_i,
  input wire logic valid_i,
  // Configuration.
  input wire logic [1:0] mode_i,
  input wire logic [7:0] assert_thr_i,
  input wire logic [7:0] clear_thr_i,
  // Result.
  output logic absent_o,
  output logic last_bit_o
);

  typedef struct packed {
    tad_run_t run;
    tad_clr_t clr;
    logic [10:0] blk;
    logic trans;
    logic have;
    logic prev;
    logic absent;
    logic last;
  } tad_det_t;

  localparam logic [10:0] BLK_LAST = 11'(BLOCK_BITS - 1);

  tad_det_t q, d;
  logic same;
  logic counts;

  always_comb begin
    d = q;
    same = q.have && (bit_i == q.prev);
    counts = (mode_i == RL_ZEROS) ? !bit_i : 1'b1;
    if (mode_i == RL_OFF) begin
      d = '0; // [R09]
    end else if (valid_i) begin
      d.have = 1'b1;
      d.prev = bit_i;
      if (!counts) begin
        d.run = '0; // [R09]
      end else if (!same) begin
        d.run = tad_run_t'(1);
      end else if (q.run != '1) begin
        d.run = q.run + tad_run_t'(1);
      end
      if (q.have && !same) begin
        d.trans = 1'b1;
      end
      if (q.blk == BLK_LAST) begin
        d.blk = '0;
        d.trans = 1'b0;
        if (q.absent && (q.trans || (q.have && !same))) begin
          if (q.clr + tad_clr_t'(1) == tad_clear_len(clear_thr_i)) begin
            d.absent = 1'b0; // [R16]
            d.clr = '0;
          end else begin
            d.clr = q.clr + tad_clr_t'(1);
          end
        end else begin
          d.clr = '0; // [R16]
        end
      end else begin
        d.blk = q.blk + 11'h001;
      end
      // Block counting restarts at an event so that only whole blocks can release it.
      if (!q.absent && counts && d.run >= tad_assert_len(assert_thr_i, BLOCK_BITS)) begin
        d.absent = 1'b1; // [R15]
        d.last = bit_i; // [R13]
        d.clr = '0;
        d.blk = '0; // [R16]
        d.trans = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign absent_o = q.absent;
  assign last_bit_o = q.last;

  property p_mode_off;
    @(posedge ref_clk_i) disable iff (reset_i) (mode_i == RL_OFF) |=> !q.absent;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("run absence while detector off"); // [R09]

  property p_last_bit;
    @(posedge ref_clk_i) disable iff (reset_i) $rose(q.absent) |-> (q.last == $past(bit_i));
  endproperty
  a_last_bit: assert property (p_last_bit) else $error("last trigger bit wrong"); // [R13]

endmodule // tad_run_detect

// [tad_alarm_bank.sv]
/*
  Transmit alarm and signal-detect register bank with interrupt logic.
  Assumes a plain register port with one-cycle strobes and synchronous inputs.
*/
// What this block does
// R01: Reference clock deviation sets alarm bit 6.
// R02: Overall signal absence shows in alarm bit 5.
// R03: PLL unlock sets lock-missing alarm bit 4.
// R04: FIFO fault bit 3, auto-recover clears it.
// R05: Pattern error count at limit sets bit 2.
// R06: Sync-missing bit 1 zero while checker off.
// R07: Eye-quality alarm in bit 0 below threshold.
// R08: Eye enable bit 3 gates eye into absence.
// R09: Mode 00 off, 01 zeros, 1x both.
// R10: Control register resets to 0x0E.
// R11: Eye absence high when value below thresholds.
// R12: Lock-missing forces eye absence to zero.
// R13: Status bit 3 holds last trigger bit.
// R14: Status bit 2 shows run-length absence.
// R15: Assert run is (thr*5+2)*1024 bits.
// R16: Clear after thr*16+1 blocks with transitions.
// R17: Signal absent is OR of run-length absence and eye alarm, each when enabled.
// R18: Reserved bits read zero, ignore writes.
`timescale 1ns/1ns
module tad_alarm_bank
  import tad_pkg::*;
#(
  parameter int BLOCK_BITS = RL_BLOCK_BITS
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Alarm sources.
  input wire logic ref_clock_deviation_i,
  input wire logic pll_unlocked_i,
  input wire logic fifo_overflow_i,
  input wire logic fifo_underflow_i,
  input wire logic pattern_enable_i,
  input wire logic pattern_sync_lost_i,
  input wire logic [7:0] pattern_error_count_i,
  input wire logic [5:0] eye_quality_value_i,
  // Serial bit stream.
  input wire logic tx_bit_i,
  input wire logic tx_bit_valid_i,
  // Outputs.
  output logic signal_absent_o,
  output logic fifo_reset_o,
  output logic irq_o
);

  // ***********************************************************
  // State.
  // ***********************************************************
  typedef struct packed {
    logic [7:0] alarm;
    logic [7:0] ctrl;
    logic [7:0] status;
    logic [7:0] a_thr;
    logic [7:0] c_thr;
    logic [7:0] eye_a;
    logic [7:0] eye_d;
    logic [7:0] path;
    logic [7:0] pat_lim;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [7:0] rdata;
    logic fifo_rst;
    logic irq;
  } tad_state_t;

  tad_state_t q, d;
  logic det_abs;
  logic det_last;
  logic fifo_ev;
  logic lock_n;
  logic eye_alarm_n;
  logic eye_abs_n;
  logic sig_n;
  logic wr_fifo_rst;
  logic [7:0] al_n;
  logic [7:0] ev;
  logic [1:0] mode;

  // ***********************************************************
  // Run-length detector.
  // ***********************************************************
  tad_run_detect #(
    .BLOCK_BITS(BLOCK_BITS)
  ) u_run (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .bit_i(tx_bit_i),
    .valid_i(tx_bit_valid_i),
    .mode_i(mode),
    .assert_thr_i(q.a_thr),
    .clear_thr_i(q.c_thr),
    .absent_o(det_abs),
    .last_bit_o(det_last)
  );

  assign mode = q.ctrl[CTL_MODE_LO +: 2];

  // ***********************************************************
  // Next state.
  // ***********************************************************
  always_comb begin
    d = q;
    d.fifo_rst = 1'b0;
    d.rdata = '0;
    fifo_ev = fifo_overflow_i || fifo_underflow_i;
    lock_n = pll_unlocked_i; // [R03]
    wr_fifo_rst = reg_wr_i && (reg_addr_i == ADDR_PATH_CFG) && reg_wdata_i[PATH_FIFO_RST];
    // Hysteresis: assert below the assert level, release at the deassert level.
    if (q.alarm[BIT_EYE]) begin
      eye_alarm_n = eye_quality_value_i < q.eye_d[5:0]; // [R07]
    end else begin
      eye_alarm_n = eye_quality_value_i < q.eye_a[7:2]; // [R07]
    end
    eye_abs_n = eye_alarm_n && !lock_n; // [R11] [R12]
    // The eye path feeds on the alarm itself, so it also acts while the PLL is unlocked.
    sig_n = ((mode != RL_OFF) && det_abs) || (q.ctrl[CTL_EYE_EN] && eye_alarm_n); // [R08] [R17]
    al_n = '0;
    al_n[BIT_REF] = ref_clock_deviation_i; // [R01]
    al_n[BIT_SIG] = sig_n; // [R02]
    al_n[BIT_LOCK] = lock_n; // [R03]
    al_n[BIT_FIFO] = fifo_ev || (q.alarm[BIT_FIFO] && !q.path[PATH_AUTO] && !wr_fifo_rst); // [R04]
    al_n[BIT_PERR] = pattern_enable_i && (pattern_error_count_i >= q.pat_lim); // [R05]
    al_n[BIT_SYNC] = pattern_enable_i && pattern_sync_lost_i; // [R06]
    al_n[BIT_EYE] = eye_alarm_n; // [R07]
    d.alarm = al_n & ALARM_MASK; // [R18]
    d.status = '0;
    d.status[ST_EYE] = eye_abs_n; // [R11]
    d.status[ST_LAST] = det_last; // [R13]
    d.status[ST_RUN] = det_abs; // [R14]
    d.status[ST_SIG] = sig_n;
    ev = al_n & ~q.alarm & ALARM_MASK;

    // Register writes; reserved bits are masked off.
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_SD_CTRL: d.ctrl = reg_wdata_i & CTRL_WMASK; // [R18]
        ADDR_ASSERT_THR: d.a_thr = reg_wdata_i;
        ADDR_CLEAR_THR: d.c_thr = reg_wdata_i;
        ADDR_EYE_ASSERT: d.eye_a = reg_wdata_i;
        ADDR_EYE_DEASSERT: d.eye_d = reg_wdata_i & EYE_D_WMASK; // [R18]
        ADDR_PATH_CFG: begin
          d.path = reg_wdata_i & PATH_WMASK; // [R18]
          d.fifo_rst = reg_wdata_i[PATH_FIFO_RST];
        end
        ADDR_PAT_LIMIT: d.pat_lim = reg_wdata_i;
        ADDR_IRQ_MASK: d.irq_mask = reg_wdata_i & ALARM_MASK; // [R18]
        default: begin
        end
      endcase
    end

    // Reads; the interrupt status clears on read, a new event wins.
    d.irq_stat = q.irq_stat | ev;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_ALARM: d.rdata = q.alarm;
        ADDR_SD_CTRL: d.rdata = q.ctrl;
        ADDR_SD_STAT: d.rdata = q.status; // [R14]
        ADDR_ASSERT_THR: d.rdata = q.a_thr;
        ADDR_CLEAR_THR: d.rdata = q.c_thr;
        ADDR_EYE_ASSERT: d.rdata = q.eye_a;
        ADDR_EYE_DEASSERT: d.rdata = q.eye_d;
        ADDR_PATH_CFG: d.rdata = q.path;
        ADDR_PAT_LIMIT: d.rdata = q.pat_lim;
        ADDR_IRQ_STAT: begin
          d.rdata = q.irq_stat;
          d.irq_stat = ev;
        end
        ADDR_IRQ_MASK: d.rdata = q.irq_mask;
        default: d.rdata = '0; // [R18]
      endcase
    end
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  // ***********************************************************
  // Registers.
  // ***********************************************************
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.ctrl <= CTRL_RST; // [R10]
      q.eye_a <= EYE_A_RST;
      q.eye_d <= EYE_D_RST;
      q.pat_lim <= PAT_LIMIT_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign signal_absent_o = q.alarm[BIT_SIG];
  assign fifo_reset_o = q.fifo_rst;
  assign irq_o = q.irq;

  // ***********************************************************
  // Assertions.
  // ***********************************************************
  property p_ref_alarm;
    @(posedge ref_clk_i) disable iff (reset_i) ref_clock_deviation_i |=> q.alarm[BIT_REF];
  endproperty
  a_ref_alarm: assert property (p_ref_alarm) else $error("ref alarm missing"); // [R01]

  property p_sig_run;
    @(posedge ref_clk_i) disable iff (reset_i)
      (det_abs && (mode != RL_OFF)) |=> signal_absent_o;
  endproperty
  a_sig_run: assert property (p_sig_run) else $error("run absence not reported"); // [R02]

  property p_lock;
    @(posedge ref_clk_i) disable iff (reset_i) pll_unlocked_i |=> q.alarm[BIT_LOCK];
  endproperty
  a_lock: assert property (p_lock) else $error("lock alarm missing"); // [R03]

  property p_fifo_set;
    @(posedge ref_clk_i) disable iff (reset_i) fifo_ev |=> q.alarm[BIT_FIFO];
  endproperty
  a_fifo_set: assert property (p_fifo_set) else $error("fifo fault not set"); // [R04]

  property p_fifo_auto;
    @(posedge ref_clk_i) disable iff (reset_i)
      (q.alarm[BIT_FIFO] && q.path[PATH_AUTO] && !fifo_ev) |=> !q.alarm[BIT_FIFO];
  endproperty
  a_fifo_auto: assert property (p_fifo_auto) else $error("fifo fault not recovered"); // [R04]

  property p_pat_err;
    @(posedge ref_clk_i) disable iff (reset_i)
      (pattern_enable_i && (pattern_error_count_i >= q.pat_lim)) |=> q.alarm[BIT_PERR];
  endproperty
  a_pat_err: assert property (p_pat_err) else $error("pattern error alarm missing"); // [R05]

  property p_sync_off;
    @(posedge ref_clk_i) disable iff (reset_i) !pattern_enable_i |=> !q.alarm[BIT_SYNC];
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync flag with checker off"); // [R06]

  property p_eye_below;
    @(posedge ref_clk_i) disable iff (reset_i)
      (!q.alarm[BIT_EYE] && (eye_quality_value_i < q.eye_a[7:2]) && !pll_unlocked_i)
      |=> (q.status[ST_EYE] && q.alarm[BIT_EYE]);
  endproperty
  a_eye_below: assert property (p_eye_below) else $error("eye absence missing"); // [R11]

  property p_eye_lock;
    @(posedge ref_clk_i) disable iff (reset_i) q.alarm[BIT_LOCK] |-> !q.status[ST_EYE];
  endproperty
  a_eye_lock: assert property (p_eye_lock) else $error("eye absence under unlock"); // [R12]

  property p_no_source;
    @(posedge ref_clk_i) disable iff (reset_i)
      (!q.ctrl[CTL_EYE_EN] && (mode == RL_OFF)) |=> !signal_absent_o;
  endproperty
  a_no_source: assert property (p_no_source) else $error("absence with no source"); // [R17]

  property p_eye_gate;
    @(posedge ref_clk_i) disable iff (reset_i)
      (q.ctrl[CTL_EYE_EN] && eye_alarm_n) |=> signal_absent_o;
  endproperty
  a_eye_gate: assert property (p_eye_gate) else $error("eye path not gated in"); // [R08]

  property p_ctrl_rst;
    @(posedge ref_clk_i) disable iff (reset_i) $past(reset_i) |-> (q.ctrl == CTRL_RST);
  endproperty
  a_ctrl_rst: assert property (p_ctrl_rst) else $error("control reset value wrong"); // [R10]

  property p_status_run;
    @(posedge ref_clk_i) disable iff (reset_i) det_abs |=> q.status[ST_RUN];
  endproperty
  a_status_run: assert property (p_status_run) else $error("run status missing"); // [R14]

  property p_rsvd_read;
    @(posedge ref_clk_i) disable iff (reset_i)
      (reg_rd_i && (reg_addr_i == ADDR_ALARM)) |=> !reg_rdata_o[7];
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bit read nonzero"); // [R18]

  property p_ref_clear;
    @(posedge ref_clk_i) disable iff (reset_i) !ref_clock_deviation_i |=> !q.alarm[BIT_REF];
  endproperty
  a_ref_clear: assert property (p_ref_clear) else $error("ref alarm stuck"); // [R01]

  property p_fifo_pulse;
    @(posedge ref_clk_i) disable iff (reset_i) wr_fifo_rst |=> fifo_reset_o;
  endproperty
  a_fifo_pulse: assert property (p_fifo_pulse) else $error("fifo reset pulse missing"); // [R04]

  property p_fifo_hold;
    @(posedge ref_clk_i) disable iff (reset_i)
      (q.alarm[BIT_FIFO] && !q.path[PATH_AUTO] && !wr_fifo_rst) |=> q.alarm[BIT_FIFO];
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("fifo fault not sticky"); // [R04]

  property p_sync_on;
    @(posedge ref_clk_i) disable iff (reset_i)
      (pattern_enable_i && pattern_sync_lost_i) |=> q.alarm[BIT_SYNC];
  endproperty
  a_sync_on: assert property (p_sync_on) else $error("sync loss not flagged"); // [R06]

  property p_eye_hold;
    @(posedge ref_clk_i) disable iff (reset_i)
      (q.alarm[BIT_EYE] && (eye_quality_value_i < q.eye_d[5:0])) |=> q.alarm[BIT_EYE];
  endproperty
  a_eye_hold: assert property (p_eye_hold) else $error("eye alarm dropped early"); // [R07]

  property p_eye_release;
    @(posedge ref_clk_i) disable iff (reset_i)
      (q.alarm[BIT_EYE] && (eye_quality_value_i >= q.eye_d[5:0])) |=> !q.alarm[BIT_EYE];
  endproperty
  a_eye_release: assert property (p_eye_release) else $error("eye alarm not released"); // [R07]

  property p_last_status;
    @(posedge ref_clk_i) disable iff (reset_i) det_last |=> q.status[ST_LAST];
  endproperty
  a_last_status: assert property (p_last_status) else $error("last bit not shown"); // [R13]

  property p_rsvd_status;
    @(posedge ref_clk_i) disable iff (reset_i)
      (reg_rd_i && (reg_addr_i == ADDR_SD_STAT))
      |=> ((reg_rdata_o[7:5] == 3'h0) && !reg_rdata_o[1]);
  endproperty
  a_rsvd_status: assert property (p_rsvd_status) else $error("status pad bits set"); // [R18]

  property p_ctrl_write;
    @(posedge ref_clk_i) disable iff (reset_i)
      (reg_wr_i && (reg_addr_i == ADDR_SD_CTRL))
      |=> (q.ctrl == ($past(reg_wdata_i) & CTRL_WMASK));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not masked"); // [R18]

  // ***********************************************************
  // Cover points.
  // ***********************************************************

  c_run_abs: cover property (@(posedge ref_clk_i) disable iff (reset_i) $rose(det_abs));
  c_run_clr: cover property (@(posedge ref_clk_i) disable iff (reset_i) $fell(det_abs));
  c_irq: cover property (@(posedge ref_clk_i) disable iff (reset_i) $rose(irq_o));
  c_fifo_pulse: cover property (@(posedge ref_clk_i) disable iff (reset_i) $rose(fifo_reset_o));
  c_eye_off: cover property (@(posedge ref_clk_i) disable iff (reset_i) $fell(q.alarm[BIT_EYE]));

endmodule // tad_alarm_bank

// [tad_alarm_bank_tb.sv]
/*
  Self-checking testbench for the transmit alarm and signal-detect register bank.
  Assumes the bank package and a run-length block size shortened to 8 bits.
*/
`timescale 1ns/1ns
module tad_alarm_bank_tb;
  import tad_pkg::*;

  // ***********************************************************
  // Signals and design instance.
  // ***********************************************************
  localparam int BLK = 8;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic ref_clock_deviation_i = 1'b0;
  logic pll_unlocked_i = 1'b0;
  logic fifo_overflow_i = 1'b0;
  logic fifo_underflow_i = 1'b0;
  logic pattern_enable_i = 1'b0;
  logic pattern_sync_lost_i = 1'b0;
  logic [7:0] pattern_error_count_i = 8'h00;
  logic [5:0] eye_quality_value_i = 6'h3F;
  logic tx_bit_i = 1'b0;
  logic tx_bit_valid_i = 1'b0;
  logic signal_absent_o;
  logic fifo_reset_o;
  logic irq_o;
  int mismatches = 0;
  int cmp_count = 0;
  logic [7:0] ex;

  tad_alarm_bank #(.BLOCK_BITS(BLK)) u_tad_alarm_bank (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ref_clock_deviation_i(ref_clock_deviation_i), .pll_unlocked_i(pll_unlocked_i),
    .fifo_overflow_i(fifo_overflow_i), .fifo_underflow_i(fifo_underflow_i),
    .pattern_enable_i(pattern_enable_i), .pattern_sync_lost_i(pattern_sync_lost_i),
    .pattern_error_count_i(pattern_error_count_i),
    .eye_quality_value_i(eye_quality_value_i),
    .tx_bit_i(tx_bit_i), .tx_bit_valid_i(tx_bit_valid_i),
    .signal_absent_o(signal_absent_o), .fifo_reset_o(fifo_reset_o), .irq_o(irq_o)
  );

  always #4 ref_clk_i = ~ref_clk_i;

  // ***********************************************************
  // Access and check tasks.
  // ***********************************************************
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // The read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    d = reg_rdata_o;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Sends n valid serial bits of one value, then idles the stream.
  task automatic send(input logic b, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      tx_bit_i <= b;
      tx_bit_valid_i <= 1'b1;
    end
    @(posedge ref_clk_i);
    tx_bit_valid_i <= 1'b0;
    cycles(2);
  endtask

  initial begin
    #400000;
    mismatches++;
    $display("FAIL watchdog expected end seen hang");
    end_sim();
  end

  // ***********************************************************
  // Main sequence.
  // ***********************************************************
  initial begin
    cycles(3);
    reset_i <= 1'b0;
    // Reset values, unmapped place and read-only writes.
    rdchk("alarm_rst", ADDR_ALARM, 8'h00);
    rdchk("ctrl_rst", ADDR_SD_CTRL, 8'h0E);
    rdchk("thr_rst", ADDR_ASSERT_THR, 8'h00);
    rdchk("unmapped", 8'h80, 8'h00);
    wr(ADDR_SD_CTRL, 8'hFF);
    rdchk("ctrl_resv", ADDR_SD_CTRL, 8'h0E);
    wr(ADDR_ALARM, 8'hFF);
    rdchk("alarm_ro", ADDR_ALARM, 8'h00);
    wr(ADDR_ASSERT_THR, 8'hA5);
    rdchk("thr_rw", ADDR_ASSERT_THR, 8'hA5);

    // Level alarms.
    rdchk("irq_clr", ADDR_IRQ_STAT, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h10);
    ref_clock_deviation_i <= 1'b1;
    pattern_sync_lost_i <= 1'b1;
    cycles(2);
    rdchk("alarm_ref", ADDR_ALARM, 8'h40);
    chk("irq_masked", 8'h00, {7'h0, irq_o});
    pattern_enable_i <= 1'b1;
    pll_unlocked_i <= 1'b1;
    pattern_error_count_i <= 8'hFF;
    cycles(3);
    rdchk("alarm_lvl", ADDR_ALARM, 8'h56);
    chk("irq_on", 8'h01, {7'h0, irq_o});
    rdchk("irq_stat", ADDR_IRQ_STAT, 8'h56);
    cycles(2);
    chk("irq_off", 8'h00, {7'h0, irq_o});
    rdchk("irq_read_clr", ADDR_IRQ_STAT, 8'h00);
    pattern_error_count_i <= 8'hFE;
    pattern_sync_lost_i <= 1'b0;
    ref_clock_deviation_i <= 1'b0;
    // Eye quality below threshold while unlocked, then locked.
    eye_quality_value_i <= 6'h00;
    cycles(3);
    rdchk("alarm_eye_lol", ADDR_ALARM, 8'h31);
    rdchk("stat_eye_lol", ADDR_SD_STAT, 8'h01);
    pll_unlocked_i <= 1'b0;
    cycles(3);
    rdchk("stat_eye", ADDR_SD_STAT, 8'h11);
    chk("sig_pin", 8'h01, {7'h0, signal_absent_o});
    wr(ADDR_SD_CTRL, 8'h06);
    cycles(2);
    rdchk("alarm_eye_off", ADDR_ALARM, 8'h01);
    rdchk("stat_eye_off", ADDR_SD_STAT, 8'h10);
    eye_quality_value_i <= 6'h3F;
    pattern_enable_i <= 1'b0;

    // FIFO fault, sticky then auto recovered.
    fifo_overflow_i <= 1'b1;
    cycles(1);
    fifo_overflow_i <= 1'b0;
    cycles(3);
    rdchk("fifo_sticky", ADDR_ALARM, 8'h08);
    wr(ADDR_PATH_CFG, 8'h01);
    cycles(1);
    chk("fifo_pulse", 8'h01, {7'h0, fifo_reset_o});
    cycles(1);
    chk("fifo_pulse_end", 8'h00, {7'h0, fifo_reset_o});
    rdchk("fifo_cleared", ADDR_ALARM, 8'h00);
    wr(ADDR_PATH_CFG, 8'h02);
    fifo_underflow_i <= 1'b1;
    cycles(1);
    fifo_underflow_i <= 1'b0;
    cycles(4);
    rdchk("fifo_auto", ADDR_ALARM, 8'h00);

    // Run-length detector in every mode, threshold 1: run of 7 blocks.
    wr(ADDR_ASSERT_THR, 8'h01);
    wr(ADDR_CLEAR_THR, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_SD_CTRL, 8'h00);
      wr(ADDR_SD_CTRL, 8'(m << 1));
      send(1'b1, 7 * BLK);
      ex = (m >= 2) ? 8'h0D : 8'h00;
      rdchk("run_ones", ADDR_SD_STAT, ex);
      wr(ADDR_SD_CTRL, 8'h00);
      wr(ADDR_SD_CTRL, 8'(m << 1));
      send(1'b0, 7 * BLK - 1);
      rdchk("run_short", ADDR_SD_STAT, 8'h00);
      send(1'b0, 1);
      ex = (m != 0) ? 8'h05 : 8'h00;
      rdchk("run_zeros", ADDR_SD_STAT, ex);
      rdchk("run_alarm", ADDR_ALARM, {2'h0, ex[0], 5'h00});
    end
    // Release after one block holding a transition.
    for (int i = 0; i < BLK; i++) begin
      send(1'(i), 1);
    end
    cycles(2);
    rdchk("run_release", ADDR_SD_STAT, 8'h00);
    end_sim();
  end

endmodule // tad_alarm_bank_tb
